//--- src/pdd_regs.sv
`timescale 1ns/10ps
module pdd_regs
	import pdd_pkg::*;
#(
	parameter int WDT_WAIT_CYCLES = PDD_WDT_WAIT_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	input  wire logic       watchdog_expired,
	input  wire logic       converter_enable,
	input  wire logic       divide_by_two_mode,
	input  wire logic       dual_phase,
	output logic            output_overvoltage_guard_off,
	output logic            input_overvoltage_guard_off,
	output logic            die_overtemp_guard_off,
	output logic            input_overcurrent_guard_off,
	output logic            wireless_reverse_current_guard_off,
	output logic            output_discharge_enable,
	output logic            soft_reset_pulse,
	output logic [3:0]      phase_a_switches,
	output logic [3:0]      phase_b_switches
);

	////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0]  prot_reg;
	logic [7:0]  disch_reg;
	logic        soft_rst_reg;
	logic        wdt_pending_reg;
	logic [31:0] wdt_count_reg;
	logic        wdt_fire;
	logic        wr_prot;
	logic        wr_disch;

	assign wr_prot  = reg_write && (reg_addr == PDD_PROT_OFFSET);
	assign wr_disch = reg_write && (reg_addr == PDD_DISCH_OFFSET);
	assign wdt_fire = wdt_pending_reg &&
		(wdt_count_reg == 32'(WDT_WAIT_CYCLES - 1));

	// Soft reset strobe; takes effect the cycle after the write
	always_ff @(posedge clk) begin
		if (rst || soft_rst_reg) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= wr_prot && reg_wdata[PDD_BIT_SOFT_RESET];
		end
	end

	assign soft_reset_pulse = soft_rst_reg;

	////////////////////////////////////////////////////////////////////////
	// Watchdog reset delay

	// Any register access clears the pending flag and count, so it cancels the wait
	always_ff @(posedge clk) begin
		if (rst || soft_rst_reg || wdt_fire || reg_write || reg_read) begin
			wdt_pending_reg <= 1'b0;
			wdt_count_reg   <= 32'h0000_0000;
		end else if (watchdog_expired && !wdt_pending_reg) begin
			wdt_pending_reg <= 1'b1;
			wdt_count_reg   <= 32'h0000_0000;
		end else if (wdt_pending_reg) begin
			wdt_count_reg <= wdt_count_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection-disable register

	always_ff @(posedge clk) begin
		if (rst || soft_rst_reg) begin
			prot_reg <= PDD_PROT_RESET;
		end else if (wdt_fire) begin
			prot_reg <= PDD_PROT_RESET;
		end else if (wr_prot) begin
			// Soft reset bit is never stored; it reads back zero
			prot_reg <= reg_wdata & PDD_PROT_WMASK;
		end
	end

	assign output_overvoltage_guard_off =
		prot_reg[PDD_BIT_OUTPUT_OVERVOLTAGE_GUARD_OFF];
	assign input_overvoltage_guard_off =
		prot_reg[PDD_BIT_INPUT_OVERVOLTAGE_GUARD_OFF];
	assign die_overtemp_guard_off =
		prot_reg[PDD_BIT_DIE_OVERTEMP_GUARD_OFF];
	assign input_overcurrent_guard_off =
		prot_reg[PDD_BIT_INPUT_OVERCURRENT_GUARD_OFF];
	assign wireless_reverse_current_guard_off =
		prot_reg[PDD_BIT_WRX_OCP_OFF];

	////////////////////////////////////////////////////////////////////////
	// Output discharge register

	// Not touched by watchdog or converter enable
	always_ff @(posedge clk) begin
		if (rst || soft_rst_reg) begin
			disch_reg <= PDD_DISCH_RESET;
		end else if (wr_disch) begin
			disch_reg <= reg_wdata & PDD_DISCH_WMASK;
		end
	end

	assign output_discharge_enable = disch_reg[PDD_BIT_DISCH_EN];

	////////////////////////////////////////////////////////////////////////
	// Read path

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			if (reg_addr == PDD_PROT_OFFSET) begin
				reg_rdata <= prot_reg & PDD_PROT_WMASK;
			end else if (reg_addr == PDD_DISCH_OFFSET) begin
				reg_rdata <= disch_reg & PDD_DISCH_WMASK;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switch sequencing

	pdd_phase_gen u_phase (
		.clk              (clk),
		.rst              (rst),
		.run              (converter_enable && divide_by_two_mode),
		.dual_phase       (dual_phase),
		.phase_a_switches (phase_a_switches),
		.phase_b_switches (phase_b_switches)
	);

endmodule

//--- inc/pdd_pkg.sv
package pdd_pkg;

	localparam logic [7:0] PDD_PROT_OFFSET      = 8'h12;
	localparam logic [7:0] PDD_DISCH_OFFSET     = 8'h13;

	localparam int PDD_BIT_OUTPUT_OVERVOLTAGE_GUARD_OFF  = 7;
	localparam int PDD_BIT_INPUT_OVERVOLTAGE_GUARD_OFF  = 6;
	localparam int PDD_BIT_DIE_OVERTEMP_GUARD_OFF  = 5;
	localparam int PDD_BIT_INPUT_OVERCURRENT_GUARD_OFF  = 4;
	localparam int PDD_BIT_WRX_OCP_OFF   = 3;
	localparam int PDD_BIT_SOFT_RESET    = 2;
	localparam int PDD_BIT_DISCH_EN      = 1;

	localparam logic [7:0] PDD_PROT_WMASK       = 8'hF8;
	localparam logic [7:0] PDD_DISCH_WMASK      = 8'h02;
	localparam logic [7:0] PDD_PROT_RESET       = 8'h00;
	localparam logic [7:0] PDD_DISCH_RESET      = 8'h00;

	localparam int PDD_CLK_MHZ          = 125;
	localparam int PDD_WDT_WAIT_MS      = 32;
	localparam int PDD_WDT_WAIT_CYCLES  = PDD_WDT_WAIT_MS * 1000 * PDD_CLK_MHZ;

	localparam logic [7:0] PDD_PHASE_DIV_DEFAULT = 8'hF9;

	typedef enum logic [1:0] {
		PDD_PH_IDLE   = 2'b00,
		PDD_PH_FIRST  = 2'b01,
		PDD_PH_SECOND = 2'b11
	} pdd_phase_type;

endpackage

//--- src/pdd_phase_gen.sv
`timescale 1ns/10ps
module pdd_phase_gen
	import pdd_pkg::*;
#(
	parameter logic [7:0] HALF_PERIOD = PDD_PHASE_DIV_DEFAULT
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       dual_phase,
	output logic [3:0]      phase_a_switches,
	output logic [3:0]      phase_b_switches
);

	pdd_phase_type state_reg;
	logic [7:0]    count_reg;
	logic          tick;

	assign tick = (count_reg == HALF_PERIOD);

	always_ff @(posedge clk) begin
		// Held in idle so the first period is full length
		if (rst || !run || tick || state_reg == PDD_PH_IDLE) begin
			count_reg <= 8'h00;
		end else begin
			count_reg <= count_reg + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !run) begin
			state_reg <= PDD_PH_IDLE;
		end else begin
			case (state_reg)
				PDD_PH_IDLE:   state_reg <= PDD_PH_FIRST;
				PDD_PH_FIRST:  if (tick) state_reg <= PDD_PH_SECOND;
				PDD_PH_SECOND: if (tick) state_reg <= PDD_PH_FIRST;
				default:       state_reg <= PDD_PH_IDLE;
			endcase
		end
	end

	// Switch order {4,3,2,1}; two-state swap keeps no overlap
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_a_switches <= 4'h0;
			phase_b_switches <= 4'h0;
		end else begin
			case (state_reg)
				PDD_PH_FIRST: begin
					phase_a_switches <= 4'h5;
					// Half a period later is 180 degrees
					phase_b_switches <= dual_phase ? 4'hA : 4'h0;
				end
				PDD_PH_SECOND: begin
					phase_a_switches <= 4'hA;
					phase_b_switches <= dual_phase ? 4'h5 : 4'h0;
				end
				default: begin
					phase_a_switches <= 4'h0;
					phase_b_switches <= 4'h0;
				end
			endcase
		end
	end

endmodule

//--- verif/pdd_regs_checker.sv
`timescale 1ns/10ps
module pdd_regs_checker
	import pdd_pkg::*;
(
	input logic       clk,
	input logic       rst,
	input logic       dual_phase,
	input logic       reg_write,
	input logic       reg_read,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	input logic       output_overvoltage_guard_off,
	input logic       input_overvoltage_guard_off,
	input logic       die_overtemp_guard_off,
	input logic       input_overcurrent_guard_off,
	input logic       wireless_reverse_current_guard_off,
	input logic       output_discharge_enable,
	input logic       soft_reset_pulse,
	input logic [3:0] phase_a_switches,
	input logic [3:0] phase_b_switches
);
	wire [7:0] g = {output_overvoltage_guard_off, input_overvoltage_guard_off,
		die_overtemp_guard_off, input_overcurrent_guard_off,
		wireless_reverse_current_guard_off, 3'h0};
	// Writes in the pulse cycle lose to the soft reset
	wire w12 = reg_write && reg_addr == PDD_PROT_OFFSET && !soft_reset_pulse;
	wire w13 = reg_write && reg_addr == PDD_DISCH_OFFSET && !soft_reset_pulse;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	property p_prot; w12 |=> g == {$past(reg_wdata[7:3]), 3'h0}; endproperty
	a_prot: assert property (p_prot)
		else $error("guard bits wrong");
	property p_srp; w12 && reg_wdata[2] |=> soft_reset_pulse
		##1 (g == 8'h00 && !output_discharge_enable && !soft_reset_pulse);
	endproperty
	a_srp: assert property (p_srp)
		else $error("soft reset wrong");
	property p_nosrp; !(w12 && reg_wdata[2]) |=> !soft_reset_pulse; endproperty
	a_nosrp: assert property (p_nosrp)
		else $error("stray soft reset");
	property p_dis; w13 |=> output_discharge_enable == $past(reg_wdata[1]);
	endproperty
	a_dis: assert property (p_dis)
		else $error("discharge bit wrong");
	property p_hold; output_discharge_enable && !w13 && !soft_reset_pulse
		|=> output_discharge_enable; endproperty
	a_hold: assert property (p_hold)
		else $error("discharge lost");
	property p_r12; reg_read && reg_addr == PDD_PROT_OFFSET
		|=> reg_rdata == $past(g);
	endproperty
	a_r12: assert property (p_r12)
		else $error("read 12 wrong");
	property p_r13; reg_read && reg_addr == PDD_DISCH_OFFSET
		|=> reg_rdata == {6'h00, $past(output_discharge_enable), 1'h0};
	endproperty
	a_r13: assert property (p_r13)
		else $error("read 13 wrong");
	property p_sw; phase_a_switches == 4'h5 && $past(phase_a_switches) == 4'hA
		|-> ##250 phase_a_switches == 4'hA; endproperty
	a_sw: assert property (p_sw)
		else $error("period wrong");
	property p_ab; phase_b_switches != 4'h0
		|-> phase_b_switches == ~phase_a_switches; endproperty
	a_ab: assert property (p_ab)
		else $error("phase b wrong");
	property p_single; !dual_phase |=> phase_b_switches == 4'h0;
	endproperty
	a_single: assert property (p_single)
		else $error("phase b active in single phase");
	c_srp: cover property (soft_reset_pulse);
	c_dis: cover property (output_discharge_enable);
	c_ab: cover property (phase_b_switches == 4'h5);
endmodule
bind pdd_regs pdd_regs_checker u_pdd_regs_checker (.*);

//--- verif/pdd_host.sv
`timescale 1ns/10ps
module pdd_host (
	input  logic       clk,
	output logic       reg_write = 1'b0,
	output logic       reg_read  = 1'b0,
	output logic [7:0] reg_addr  = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	input  logic [7:0] reg_rdata
);
	// Released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
		@(negedge clk);
		{reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		{reg_addr, reg_read} = {a, 1'b1};
		@(negedge clk);
		{reg_addr, reg_read} = {~a, 1'b0};
		d = reg_rdata;
	endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic       clk = 1'b0, rst = 1'b1, wde = 1'b0, cen = 1'b0;
	logic       div = 1'b0, dph = 1'b0, reg_write, reg_read, dis, srp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [3:0] pa, pb;
	wire  [7:3] g;
	int         n_fail = 0, cmp_count = 0, cyc = 0, k = 0;
	always #4 clk = ~clk;
	pdd_host u_pdd_host (.clk, .reg_write, .reg_read, .reg_addr, .reg_wdata,
		.reg_rdata);
	// Short watchdog wait keeps the run brief
	pdd_regs #(.WDT_WAIT_CYCLES(20)) u_pdd_regs (.clk, .rst, .reg_write,
		.reg_read, .reg_addr, .reg_wdata, .reg_rdata,
		.watchdog_expired(wde), .converter_enable(cen),
		.divide_by_two_mode(div), .dual_phase(dph),
		.output_overvoltage_guard_off(g[7]),
		.input_overvoltage_guard_off(g[6]), .die_overtemp_guard_off(g[5]),
		.input_overcurrent_guard_off(g[4]),
		.wireless_reverse_current_guard_off(g[3]),
		.output_discharge_enable(dis), .soft_reset_pulse(srp),
		.phase_a_switches(pa), .phase_b_switches(pb));
	////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		u_pdd_host.rd(8'h12, d);
		chk(d, 8'h00);
		u_pdd_host.rd(8'h13, d);
		chk(d, 8'h00);
		for (int i = 3; i < 8; i++) begin
			u_pdd_host.wr(8'h12, 8'h01 << i);
			chk({g, 3'h0}, 8'h01 << i);
			u_pdd_host.rd(8'h12, d);
			chk(d, 8'h01 << i);
		end
		u_pdd_host.wr(8'h12, 8'hFB);
		u_pdd_host.wr(8'h13, 8'hFF);
		u_pdd_host.rd(8'h12, d);
		chk(d, 8'hF8);
		u_pdd_host.rd(8'h13, d);
		chk(d, 8'h02);
		u_pdd_host.rd(8'h14, d);
		chk(d, 8'h00);
		u_pdd_host.wr(8'h12, 8'h00);
		chk({g, 2'h0, dis}, 8'h01);
		u_pdd_host.wr(8'h12, 8'h84);
		chk({g, 2'h0, srp}, 8'h81);
		@(negedge clk);
		chk({g, 1'h0, srp, dis}, 8'h00);
		u_pdd_host.wr(8'h12, 8'hF8);
		u_pdd_host.wr(8'h13, 8'h02);
		wde = 1'b1;
		@(negedge clk);
		wde = 1'b0;
		// Bits hold through the last wait cycle, clear on the next
		repeat (19) @(negedge clk);
		chk({g, 2'h0, dis}, 8'hF9);
		@(negedge clk);
		chk({g, 2'h0, dis}, 8'h01);
		u_pdd_host.wr(8'h12, 8'hF8);
		wde = 1'b1;
		@(negedge clk);
		wde = 1'b0;
		u_pdd_host.rd(8'h12, d);
		repeat (30) @(negedge clk);
		chk({g, 2'h0, dis}, 8'hF9);
		{cen, div, dph} = 3'b111;
		for (k = 0; k < 600 && pa !== 4'hA; k++)
			@(negedge clk);
		chk({pa, pb}, 8'hA5);
		for (k = 0; k < 600 && pa !== 4'h5; k++)
			@(negedge clk);
		chk({pa, pb}, 8'h5A);
		chk(8'(k), 8'hFA);
		dph = 1'b0;
		repeat (2) @(negedge clk);
		chk({4'h0, pb}, 8'h00);
		u_pdd_host.wr(8'h13, 8'h02);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk({g, 2'h0, dis}, 8'h00);
		chk({pa, pb}, 8'h00);
		rst = 1'b0;
		repeat (300) @(negedge clk);
		tally_and_finish;
	end
endmodule
